// *** src/alu8_unit.sv ***
// 8-bit arithmetic and logic unit: byte ops in one cycle, word ops in two
// Behaviour
// [RULE_01] Register add and add-with-carry write the sum, update Z C N V H, in one cycle.
// [RULE_02] Word add of a constant to a pair writes the pair back, updates Z C N V S, in two.
// [RULE_03] Register subtract and subtract-with-borrow write the difference, Z C N V H, one cycle.
// [RULE_04] Immediate subtract writes destination minus constant, updates Z C N V H, one cycle.
// [RULE_05] Immediate subtract with borrow also takes the carry off, Z C N V H, one cycle.
// [RULE_06] Word subtract of a constant from a pair writes the pair, updates Z C N V S, in two.
// [RULE_07] AND with a register or constant writes the result, updates only Z N V, one cycle.
// [RULE_08] OR with a register or constant writes the result, updates only Z N V, one cycle.
// [RULE_09] Exclusive-or of destination and source writes the result, updates Z N V, one cycle.
// [RULE_10] Invert writes 0xFF minus the destination, updates Z C N V, one cycle.
// [RULE_11] Every flag an operation does not list keeps its earlier value.
// [RULE_12] Z is all-zero result, N the top bit, V signed overflow, H bit-3 carry, S is N xor V.
`timescale 1ns/10ps
module alu8_unit (
  input  wire logic        CLK,             // core clock, 25 MHz
  input  wire logic        RESET,           // asynchronous, active high
  input  wire logic        OP_START,        // decoder presents an operation
  input  wire logic [3:0]  OP_CODE,         // operation select
  input  wire logic [7:0]  DEST_OPERAND,    // destination register value
  input  wire logic [7:0]  SOURCE_OPERAND,  // source register value
  input  wire logic [7:0]  IMM_CONST,       // immediate constant
  input  wire logic [15:0] PAIR_OPERAND,    // register pair, high:low
  output logic             OP_BUSY,         // word op in its second cycle
  output logic             OP_DONE,         // operation finished
  output logic             WR_BYTE_EN,      // write RESULT[7:0] to destination
  output logic             WR_PAIR_EN,      // write RESULT to the register pair
  output logic [15:0]      RESULT,          // result to the register file
  output logic [5:0]       STATUS_FLAGS     // H S V N Z C
);
  alu8_pkg::alu8_state_t state_q;
  alu8_pkg::alu8_state_t state_d;
  logic [5:0]  flags_q;
  logic [5:0]  flags_d;
  logic [15:0] result_q;
  logic        wr_byte_q;
  logic        wr_pair_q;
  logic [7:0]  lo_q;
  logic [7:0]  hi_q;
  logic        carry_lo_q;
  logic        word_sub_q;

  // operation decode
  wire alu8_pkg::alu8_op_t op = alu8_pkg::alu8_op_t'(OP_CODE);
  wire logic op_known  = OP_CODE <= alu8_pkg::OP_LAST;
  wire logic idle      = state_q == alu8_pkg::ST_IDLE;
  wire logic accept    = OP_START && idle && op_known;
  wire logic is_word   = (op == alu8_pkg::OP_ADD_IMMEDIATE_WORD) ||
                         (op == alu8_pkg::OP_WORD_IMMEDIATE_MINUS);
  wire logic word_sub  = op == alu8_pkg::OP_WORD_IMMEDIATE_MINUS;
  wire logic is_invert = op == alu8_pkg::OP_BITWISE_INVERT;
  wire logic is_and    = (op == alu8_pkg::OP_AND_REG) || (op == alu8_pkg::OP_AND_IMMEDIATE);
  wire logic is_or     = (op == alu8_pkg::OP_OR_REG) || (op == alu8_pkg::OP_OR_IMMEDIATE);
  wire logic is_xor    = op == alu8_pkg::OP_EXCLUSIVE_OR;
  wire logic is_logic  = is_and || is_or || is_xor;
  wire logic is_sub    = (op == alu8_pkg::OP_SUB) ||
                         (op == alu8_pkg::OP_MINUS_IMMEDIATE) ||
                         (op == alu8_pkg::OP_BORROW_REGISTER_MINUS) ||
                         (op == alu8_pkg::OP_BORROW_IMMEDIATE_MINUS) ||
                         is_invert;
  wire logic use_carry = (op == alu8_pkg::OP_ADD_CARRY) ||
                         (op == alu8_pkg::OP_BORROW_REGISTER_MINUS) ||
                         (op == alu8_pkg::OP_BORROW_IMMEDIATE_MINUS);
  wire logic use_imm   = (op == alu8_pkg::OP_MINUS_IMMEDIATE) ||
                         (op == alu8_pkg::OP_BORROW_IMMEDIATE_MINUS) ||
                         (op == alu8_pkg::OP_AND_IMMEDIATE) ||
                         (op == alu8_pkg::OP_OR_IMMEDIATE);
  wire logic carry_flag = flags_q[alu8_pkg::FLAG_C];

  // byte operand selection; invert runs as 0xFF minus the destination
  wire logic [7:0] rhs      = use_imm ? IMM_CONST : SOURCE_OPERAND;
  wire logic [7:0] byte_a   = is_invert ? alu8_pkg::INVERT_BASE : DEST_OPERAND;  // RULE_10
  wire logic [7:0] byte_b   = is_invert ? DEST_OPERAND : rhs;
  wire logic       byte_cin = use_carry && carry_flag;  // RULE_01

  // the word ops share the byte adder: low byte with the constant first,
  // then high byte with the saved carry, trading a cycle for area
  wire logic       hi_stage = state_q == alu8_pkg::ST_WORD_HIGH;
  wire logic [7:0] add_a    = hi_stage ? hi_q : (is_word ? PAIR_OPERAND[7:0] : byte_a);
  wire logic [7:0] add_b    = hi_stage ? alu8_pkg::BYTE_ZERO : (is_word ? IMM_CONST : byte_b);
  wire logic       add_cin  = hi_stage ? carry_lo_q : (!is_word && byte_cin);
  wire logic       add_sub  = hi_stage ? word_sub_q : (is_word ? word_sub : is_sub);
  logic [7:0] add_sum;
  logic       add_cout;
  logic       add_half;
  logic       add_ovf;

  alu8_adder #(
    .W    (alu8_pkg::DATA_W)
  ) u_adder (
    .a    (add_a),
    .b    (add_b),
    .cin  (add_cin),
    .sub  (add_sub),
    .sum  (add_sum),
    .cout (add_cout),
    .half (add_half),
    .ovf  (add_ovf)
  );

  // bitwise results never overflow, so V is cleared for them
  wire logic [7:0] logic_res = is_and ? (DEST_OPERAND & rhs) :          // RULE_07
                               is_or  ? (DEST_OPERAND | rhs) :          // RULE_08
                                        (DEST_OPERAND ^ SOURCE_OPERAND); // RULE_09
  wire logic [7:0]  byte_res = is_logic ? logic_res : add_sum;
  wire logic [15:0] word_res = {add_sum, lo_q};

  // flag masks per operation class
  wire logic [5:0] byte_upd = is_logic  ? alu8_pkg::UPD_LOGIC :   // RULE_07 RULE_08 RULE_09
                              is_invert ? alu8_pkg::UPD_INVERT :  // RULE_10
                                          alu8_pkg::UPD_ARITH;    // RULE_01 RULE_03 RULE_04
  wire logic [5:0] flag_upd = hi_stage ? alu8_pkg::UPD_WORD :     // RULE_02 RULE_06
                              (accept && !is_word) ? byte_upd :
                              alu8_pkg::UPD_NONE;                 // RULE_11
  wire logic f_zero = hi_stage ? (word_res == 16'h0000) : (byte_res == alu8_pkg::BYTE_ZERO);
  wire logic f_neg  = hi_stage ? add_sum[7] : byte_res[7];
  wire logic f_ovf  = !hi_stage && is_logic ? 1'b0 : add_ovf;

  alu8_flags u_flags (
    .flags_q (flags_q),
    .upd     (flag_upd),
    .c       (add_cout),
    .h       (add_half),
    .v       (f_ovf),
    .zero    (f_zero),
    .neg     (f_neg),
    .flags_d (flags_d)
  );  // RULE_12

  // sequencing: byte ops finish at the next edge, word ops one edge later
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      alu8_pkg::ST_IDLE: begin
        if (accept && is_word) begin
          state_d = alu8_pkg::ST_WORD_HIGH;  // RULE_02 RULE_06
        end
      end
      alu8_pkg::ST_WORD_HIGH: begin
        state_d = alu8_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= alu8_pkg::ST_IDLE;
      flags_q <= alu8_pkg::FLAGS_RESET;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;  // RULE_11
    end
  end

  // low-stage context for the second word cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lo_q       <= 8'h00;
      hi_q       <= 8'h00;
      carry_lo_q <= 1'b0;
      word_sub_q <= 1'b0;
    end else if (accept && is_word) begin
      lo_q       <= add_sum;
      hi_q       <= PAIR_OPERAND[15:8];
      carry_lo_q <= add_cout;
      word_sub_q <= word_sub;
    end
  end

  // write-back strobes and result
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      result_q  <= 16'h0000;
      wr_byte_q <= 1'b0;
      wr_pair_q <= 1'b0;
    end else begin
      wr_byte_q <= accept && !is_word;  // RULE_01 RULE_03 RULE_04 RULE_05
      wr_pair_q <= hi_stage;            // RULE_02 RULE_06
      if (hi_stage) begin
        result_q <= word_res;
      end else if (accept && !is_word) begin
        result_q <= {8'h00, byte_res};
      end
    end
  end

  assign OP_BUSY      = hi_stage;
  assign OP_DONE      = wr_byte_q || wr_pair_q;
  assign WR_BYTE_EN   = wr_byte_q;
  assign WR_PAIR_EN   = wr_pair_q;
  assign RESULT       = result_q;
  assign STATUS_FLAGS = flags_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_add_carry_sum: // RULE_01
    assert property (accept && op == alu8_pkg::OP_ADD_CARRY |=> WR_BYTE_EN &&
      RESULT[7:0] == 8'($past(DEST_OPERAND) + $past(SOURCE_OPERAND) + $past(carry_flag)))
    else $error("add with carry result or timing wrong");

  a_word_add_two: // RULE_02
    assert property (accept && op == alu8_pkg::OP_ADD_IMMEDIATE_WORD |=>
      !WR_PAIR_EN && OP_BUSY ##1
      WR_PAIR_EN && RESULT == 16'($past(PAIR_OPERAND, 2) + $past(IMM_CONST, 2)))
    else $error("word add result or cycle count wrong");

  a_sub_borrow_res: // RULE_03
    assert property (accept && op == alu8_pkg::OP_BORROW_REGISTER_MINUS |=>
      RESULT[7:0] == 8'($past(DEST_OPERAND) - $past(SOURCE_OPERAND) - $past(carry_flag)))
    else $error("register subtract with borrow wrong");

  a_imm_sub_carry: // RULE_04
    assert property (accept && op == alu8_pkg::OP_MINUS_IMMEDIATE |=>
      STATUS_FLAGS[alu8_pkg::FLAG_C] == ($past(IMM_CONST) > $past(DEST_OPERAND)) &&
      RESULT[7:0] == 8'($past(DEST_OPERAND) - $past(IMM_CONST)))
    else $error("immediate subtract result or borrow wrong");

  a_imm_borrow_res: // RULE_05
    assert property (accept && op == alu8_pkg::OP_BORROW_IMMEDIATE_MINUS |=>
      WR_BYTE_EN && RESULT[7:0] == 8'($past(DEST_OPERAND) - $past(IMM_CONST) - $past(carry_flag)))
    else $error("immediate subtract with borrow wrong");

  a_word_sub_flags: // RULE_06
    assert property (accept && op == alu8_pkg::OP_WORD_IMMEDIATE_MINUS |=> ##1
      WR_PAIR_EN && RESULT == 16'($past(PAIR_OPERAND, 2) - $past(IMM_CONST, 2)) &&
      STATUS_FLAGS[alu8_pkg::FLAG_C] == ($past(IMM_CONST, 2) > $past(PAIR_OPERAND, 2)))
    else $error("word subtract result or borrow wrong");

  a_and_keeps_c: // RULE_07
    assert property (accept && is_and |=> RESULT[7:0] == ($past(DEST_OPERAND) & $past(rhs)) &&
      $stable(STATUS_FLAGS[alu8_pkg::FLAG_C]) && !STATUS_FLAGS[alu8_pkg::FLAG_V])
    else $error("and result or flag handling wrong");

  a_or_result: // RULE_08
    assert property (accept && is_or |=> WR_BYTE_EN &&
      RESULT[7:0] == ($past(DEST_OPERAND) | $past(rhs)) &&
      STATUS_FLAGS[alu8_pkg::FLAG_N] == RESULT[7])
    else $error("or result or negative flag wrong");

  a_xor_zero: // RULE_09
    assert property (accept && is_xor |=>
      RESULT[7:0] == ($past(DEST_OPERAND) ^ $past(SOURCE_OPERAND)) &&
      STATUS_FLAGS[alu8_pkg::FLAG_Z] == (RESULT[7:0] == 8'h00))
    else $error("exclusive-or result or zero flag wrong");

  a_invert_value: // RULE_10
    assert property (accept && is_invert |=>
      RESULT[7:0] == 8'(8'hFF - $past(DEST_OPERAND)) && !STATUS_FLAGS[alu8_pkg::FLAG_C])
    else $error("invert result or carry wrong");

  a_flags_held: // RULE_11
    assert property (!accept && !OP_BUSY |=> $stable(STATUS_FLAGS))
    else $error("flags changed without an operation");

  a_sign_on_word: // RULE_12
    assert property (WR_PAIR_EN |-> STATUS_FLAGS[alu8_pkg::FLAG_S] ==
      (STATUS_FLAGS[alu8_pkg::FLAG_N] ^ STATUS_FLAGS[alu8_pkg::FLAG_V]) &&
      STATUS_FLAGS[alu8_pkg::FLAG_N] == RESULT[15])
    else $error("sign or negative flag wrong after word op");

  // a request in the busy cycle must not sneak a byte write in beside the pair write
  a_busy_refused: // RULE_02
    assert property (OP_BUSY |=> WR_PAIR_EN && !WR_BYTE_EN)
    else $error("request taken while word op busy");

  a_add_half_carry: // RULE_12
    assert property (accept && op == alu8_pkg::OP_ADD |=>
      STATUS_FLAGS[alu8_pkg::FLAG_H] ==
        (({1'b0, $past(DEST_OPERAND[3:0])} + {1'b0, $past(SOURCE_OPERAND[3:0])}) > 5'h0F) &&
      STATUS_FLAGS[alu8_pkg::FLAG_C] ==
        (({1'b0, $past(DEST_OPERAND)} + {1'b0, $past(SOURCE_OPERAND)}) > 9'h0FF))
    else $error("add carry or half-carry flag wrong");

  a_byte_keeps_s: // RULE_11
    assert property (accept && !is_word |=> $stable(STATUS_FLAGS[alu8_pkg::FLAG_S]))
    else $error("byte operation changed the sign flag");

  a_word_keeps_h: // RULE_11
    assert property (WR_PAIR_EN |-> $stable(STATUS_FLAGS[alu8_pkg::FLAG_H]))
    else $error("word operation changed the half-carry flag");

  a_refused_code: // RULE_11
    assert property (OP_START && idle && !op_known |=> !OP_DONE && $stable(STATUS_FLAGS))
    else $error("undefined operation code was not ignored");
endmodule

// *** include/alu8_pkg.sv ***
// shared constants and types for the 8-bit arithmetic and logic unit
package alu8_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int FLAG_W = 6;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // which flags each class of operation may touch
  localparam logic [5:0] UPD_ARITH  = 6'h2F;
  localparam logic [5:0] UPD_WORD   = 6'h1F;
  localparam logic [5:0] UPD_LOGIC  = 6'h0E;
  localparam logic [5:0] UPD_INVERT = 6'h0F;
  localparam logic [5:0] UPD_NONE   = 6'h00;

  localparam logic [7:0] INVERT_BASE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // cycles from the accepting edge to the write pulse
  localparam int BYTE_OP_CYCLES = 1;
  localparam int WORD_OP_CYCLES = 2;

  typedef enum logic [3:0] {
    OP_ADD                  = 4'h0,
    OP_ADD_CARRY            = 4'h1,
    OP_ADD_IMMEDIATE_WORD   = 4'h2,
    OP_SUB                  = 4'h3,
    OP_MINUS_IMMEDIATE      = 4'h4,
    OP_BORROW_REGISTER_MINUS = 4'h5,
    OP_BORROW_IMMEDIATE_MINUS = 4'h6,
    OP_WORD_IMMEDIATE_MINUS = 4'h7,
    OP_AND_REG              = 4'h8,
    OP_AND_IMMEDIATE        = 4'h9,
    OP_OR_REG               = 4'hA,
    OP_OR_IMMEDIATE         = 4'hB,
    OP_EXCLUSIVE_OR         = 4'hC,
    OP_BITWISE_INVERT       = 4'hD
  } alu8_op_t;

  localparam logic [3:0] OP_LAST = 4'hD;

  typedef enum logic {
    ST_IDLE      = 1'b0,
    ST_WORD_HIGH = 1'b1
  } alu8_state_t;
endpackage

// *** src/alu8_adder.sv ***
// byte adder/subtractor with carry, half-carry and overflow
`timescale 1ns/10ps
module alu8_adder #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,     // minuend or first addend
  input  wire logic [W-1:0] b,     // subtrahend or second addend
  input  wire logic         cin,   // carry in, or borrow in when subtracting
  input  wire logic         sub,   // 1: a - b - cin
  output logic [W-1:0]      sum,   // result
  output logic              cout,  // carry out, or borrow out
  output logic              half,  // carry or borrow at bit 3
  output logic              ovf    // two's-complement overflow
);
  wire logic [W-1:0] b_eff  = sub ? ~b : b;
  wire logic         c_eff  = sub ? ~cin : cin;
  wire logic [W:0]   full   = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
  wire logic [4:0]   nibble = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};

  // subtraction as a + ~b + 1: the raw carries are inverted borrows
  assign sum  = full[W-1:0];
  assign cout = sub ? ~full[W] : full[W];
  assign half = sub ? ~nibble[4] : nibble[4];
  assign ovf  = (a[W-1] == b_eff[W-1]) && (full[W-1] != a[W-1]);
endmodule

// *** src/alu8_flags.sv ***
// merges freshly computed flags into the held status under a mask
`timescale 1ns/10ps
module alu8_flags (
  input  wire logic [5:0] flags_q,  // held status
  input  wire logic [5:0] upd,      // flags the current operation changes
  input  wire logic       c,        // candidate carry
  input  wire logic       h,        // candidate half-carry
  input  wire logic       v,        // candidate overflow
  input  wire logic       zero,     // result is all zeros
  input  wire logic       neg,      // top bit of the result
  output logic [5:0]      flags_d   // next status
);
  logic [5:0] cand;

  always_comb begin
    cand                   = alu8_pkg::FLAGS_RESET;
    cand[alu8_pkg::FLAG_C] = c;
    cand[alu8_pkg::FLAG_Z] = zero;
    cand[alu8_pkg::FLAG_N] = neg;
    cand[alu8_pkg::FLAG_V] = v;
    cand[alu8_pkg::FLAG_S] = neg ^ v;
    cand[alu8_pkg::FLAG_H] = h;
  end

  for (genvar i = 0; i < 6; i++) begin : g_bit
    assign flags_d[i] = upd[i] ? cand[i] : flags_q[i];
  end
endmodule

// *** tb/alu8_regfile_model.sv ***
// register file model on the far side: keeps what the unit writes back
`timescale 1ns/10ps
module alu8_regfile_model (
  input  wire logic        clk,       // core clock
  input  wire logic        rst,       // asynchronous, active high
  input  wire logic        wr_byte,   // byte write strobe from the unit
  input  wire logic        wr_pair,   // pair write strobe from the unit
  input  wire logic [15:0] result,    // write-back value
  output logic      [7:0]  dest_reg,  // last destination byte written
  output logic      [15:0] pair_reg   // last register pair written
);
  // strobes last one cycle, so the value is taken only on that edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dest_reg <= 8'h00;
      pair_reg <= 16'h0000;
    end else begin
      if (wr_byte) dest_reg <= result[7:0];
      if (wr_pair) pair_reg <= result;
    end
  end
endmodule

// *** tb/alu8_unit_tb.sv ***
// self-checking bench for the 8-bit arithmetic and logic unit
`timescale 1ns/10ps
module alu8_unit_tb;
  logic        clk, rst, start;
  logic [3:0]  code;
  logic [7:0]  dop, sop, imm;
  logic [15:0] pop;
  logic        busy, done, wr_b, wr_p;
  logic [15:0] res;
  logic [5:0]  flags;
  logic [7:0]  rf_byte;
  logic [15:0] rf_pair;
  logic [39:0] exp_q[$];
  logic [39:0] e;
  logic [5:0]  flg;
  logic [7:0]  last_b;
  logic [15:0] last_p;
  int          errors, n_checks, cyc;

  alu8_unit alu8_unit_inst (.CLK(clk), .RESET(rst), .OP_START(start), .OP_CODE(code),
    .DEST_OPERAND(dop), .SOURCE_OPERAND(sop), .IMM_CONST(imm), .PAIR_OPERAND(pop),
    .OP_BUSY(busy), .OP_DONE(done), .WR_BYTE_EN(wr_b), .WR_PAIR_EN(wr_p), .RESULT(res),
    .STATUS_FLAGS(flags));
  alu8_regfile_model alu8_regfile_model_inst (.clk(clk), .rst(rst), .wr_byte(wr_b),
    .wr_pair(wr_p), .result(res), .dest_reg(rf_byte), .pair_reg(rf_pair));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // expected {due cycle, byte en, pair en, result, flags}; called just after an edge
  task automatic issue(input logic [3:0] op, input logic [7:0] d, s, k, input logic [15:0] p);
    logic [8:0]  r9;
    logic [16:0] r17;
    logic [7:0]  b, r;
    logic [5:0]  f;
    logic        cin, wrd, sb;
    logic [15:0] due;
    f = flg;
    wrd = (op == 4'h2) || (op == 4'h7);
    sb = op inside {4'h3, 4'h4, 4'h5, 4'h6};
    b = (op inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hC}) ? s : k;
    cin = (op inside {4'h1, 4'h5, 4'h6}) ? flg[0] : 1'b0;
    r = 8'h00;
    r17 = 17'h00000;
    if (op <= 4'h1) begin
      r9 = {1'b0, d} + {1'b0, b} + {8'h00, cin};
      r = r9[7:0];
      f[0] = r9[8];
      f[5] = (d[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & d[3]);
      f[3] = (d[7] == b[7]) && (r[7] != d[7]);
    end else if (sb) begin
      r9 = {1'b0, d} - {1'b0, b} - {8'h00, cin};
      r = r9[7:0];
      f[0] = r9[8];
      f[5] = (~d[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~d[3]);
      f[3] = (d[7] != b[7]) && (r[7] != d[7]);
    end else if (wrd) begin
      r17 = (op == 4'h2) ? {1'b0, p} + {9'h000, k} : {1'b0, p} - {9'h000, k};
      f[0] = r17[16];
      f[3] = (op == 4'h2) ? (~p[15] & r17[15]) : (p[15] & ~r17[15]);
      f[1] = (r17[15:0] == 16'h0000);
      f[2] = r17[15];
      f[4] = f[2] ^ f[3];
    end else begin
      if (op == 4'h8 || op == 4'h9) r = d & b;
      if (op == 4'hA || op == 4'hB) r = d | b;
      if (op == 4'hC) r = d ^ b;
      if (op == 4'hD) begin
        r = 8'hFF - d;
        f[0] = 1'b0;
      end
      f[3] = 1'b0;
    end
    if (!wrd) begin
      f[1] = (r == 8'h00);
      f[2] = r[7];
      r17 = {9'h000, r};
    end
    // codes above the last one are ignored: nothing queued, flags kept
    if (op <= 4'hD) begin
      // one edge to accept, then the operation's own cycles to the strobe
      due = 16'(cyc + 1 + (wrd ? alu8_pkg::WORD_OP_CYCLES : alu8_pkg::BYTE_OP_CYCLES));
      exp_q.push_back({due, ~wrd, wrd, r17[15:0], f});
      flg = f;
      if (wrd) last_p = r17[15:0];
      else last_b = r;
    end
    start = 1'b1;
    code = op;
    dop = d;
    sop = s;
    imm = k;
    pop = p;
    @(posedge clk);
    #1;
    if (op <= 4'hD && wrd) begin
      check({39'h0, busy}, 40'h1);
      // a request while busy must be dropped; destination, constant and pair operands no longer hold either
      code = 4'h0;
      dop = ~d;
      imm = ~k;
      pop = ~p;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic idle(input int n);
    start = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      tally_and_finish();
    end else if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] t=%0t got %h exp %h", $time, res, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        check({16'(cyc), wr_b, wr_p, res, flags}, e);
      end
    end
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    code = 4'h0;
    dop = 8'h00;
    sop = 8'h00;
    imm = 8'h00;
    pop = 16'h0000;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    flg = 6'h00;
    last_b = 8'h00;
    last_p = 16'h0000;
    void'($urandom(32'heb1b));
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    check({18'h00000, res, flags}, 40'h0);
    // every code once, E and F included, back to back
    for (int i = 0; i < 16; i++) begin
      issue(4'(i), 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom));
    end
    issue(4'h0, 8'hFF, 8'h01, 8'h00, 16'h0000);
    issue(4'h1, 8'h0F, 8'h70, 8'h00, 16'h0000);
    issue(4'h3, 8'h10, 8'h01, 8'h00, 16'h0000);
    issue(4'h5, 8'h80, 8'h7F, 8'h00, 16'h0000);
    issue(4'h4, 8'h00, 8'h00, 8'h01, 16'h0000);
    issue(4'h6, 8'h01, 8'h00, 8'h00, 16'h0000);
    issue(4'h2, 8'h00, 8'h00, 8'h01, 16'hFFFF);
    issue(4'h2, 8'h00, 8'h00, 8'h01, 16'h7FFF);
    issue(4'h7, 8'h00, 8'h00, 8'h01, 16'h0000);
    issue(4'h7, 8'h00, 8'h00, 8'hFF, 16'h8000);
    issue(4'h9, 8'hF0, 8'h00, 8'h0F, 16'h0000);
    issue(4'hB, 8'h80, 8'h00, 8'h00, 16'h0000);
    issue(4'hC, 8'h5A, 8'h5A, 8'h00, 16'h0000);
    issue(4'hD, 8'h00, 8'h00, 8'h00, 16'h0000);
    issue(4'hD, 8'hFF, 8'h00, 8'h00, 16'h0000);
    // mid-run reset: outputs and held flags go back to zero, model follows
    idle(2);
    rst = 1'b1;
    flg = 6'h00;
    last_b = 8'h00;
    last_p = 16'h0000;
    idle(2);
    check({18'h00000, res, flags}, 40'h0);
    rst = 1'b0;
    for (int i = 0; i < 200; i++) begin
      issue(4'($urandom % 16), 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom));
      if ($urandom % 4 == 0) idle(1);
    end
    idle(4);
    check({24'h000000, rf_pair}, {24'h000000, last_p});
    check({32'h00000000, rf_byte}, {32'h00000000, last_b});
    check({39'h0, exp_q.size() == 0}, 40'h1);
    tally_and_finish();
  end
endmodule
